// ### inc/mss_consts.svh
// Purpose: Constants for the maintenance slot scheduler.
// Assumes: Included by bare name from the package and the verification files.
// Notes: Codes are 4-bit command codes, 3-bit processor codes.
`ifndef MSS_CONSTS_SVH
`define MSS_CONSTS_SVH

`define MSS_VP_W 3
`define MSS_CMD_W 4
`define MSS_TS_W 4
`define MSS_NUM_VP 8
`define MSS_TS_DEPTH 16
`define MSS_CMD_NOP 4'h0
`define MSS_CMD_1 4'h1
`define MSS_CMD_2 4'h2
`define MSS_CMD_7 4'h7
`define MSS_CMD_B 4'hB
`define MSS_CMD_C 4'hC
`define MSS_CMD_D 4'hD
`define MSS_CMD_E 4'hE
`define MSS_CMD_F 4'hF
`define MSS_CMD_A 4'hA
`define MSS_TS_ZERO 4'h0
`define MSS_TS_QUARTER_LSB 1:0
`define MSS_VP_DLY 3

// APB register byte addresses
`define MSS_A_CTRL 12'h000
`define MSS_A_CMD 12'h004
`define MSS_A_OVR 12'h008
`define MSS_A_TSTAB 12'h00C
`define MSS_A_STAT 12'h010
`define MSS_A_SWREG 12'h014
`define MSS_A_DISP 12'h018
`define MSS_A_MDB 12'h01C
`define MSS_A_ADDR_W 12

// Control register fields
`define MSS_CTL_MODE 1:0
`define MSS_CTL_PPBST 2
`define MSS_CTL_PERMIT 3
`define MSS_CTL_SEL 6:4
`define MSS_CTL_MASK 10:8
`define MSS_CTL_CONT 11
// Command register fields
`define MSS_CMD_CODE 3:0
`define MSS_CMD_REGVP 6:4
`define MSS_CMD_UT 15:8
`define MSS_CMD_DSRC 16
`define MSS_CMD_OSRC 17
// Time slot table write fields
`define MSS_TSW_IDX 3:0
`define MSS_TSW_VP 6:4
`define MSS_TSW_ACT 8

`endif

// ### inc/mss_pkg.sv
// Purpose: Types for the maintenance slot scheduler.
// Assumes: Constants header holds all numbers.
// Notes: Types only.
`include "mss_consts.svh"
package mss_pkg;
   typedef enum logic [1:0] {
      MSS_MODE_NORMAL,
      MSS_MODE_SEMI,
      MSS_MODE_MANUAL
   } mss_mode_t;
   typedef enum logic [1:0] {
      MSS_ST_READY,
      MSS_ST_RUN,
      MSS_ST_DONE
   } mss_state_t;
endpackage : mss_pkg

// ### rtl/mss_sched.sv
// Purpose: Slot scheduler for processor codes, active bits and test mode.
// Assumes: APB slave at 10 MHz, pclk only, presetn asynchronous.
// Notes: Time slot table held as an internal array written over APB.
// Overview of operation
// [RULE_01] Register-field processor code delayed one clock for commands 2-7.
// [RULE_02] Otherwise use the first-stage code.
// [RULE_03] Selected code passes three flip-flop stages to become current; here three stages give the next code, current comes one flop later.
// [RULE_04] Next code picks instruction register; current code broadcast.
// [RULE_05] Active forced one in manual non-burst, or normal at slot zero.
// [RULE_06] Else active bit read from slot table at counter value.
// [RULE_07] Override byte can clear a processor's active bit.
// [RULE_08] Console-selected processor overridable only with permit switch.
// [RULE_09] Burst/continuous command passes active bit only on slots 0,4,8,12.
// [RULE_10] Burst and continuous commands legal only in manual mode.
// [RULE_11] Second of two consecutive same-processor slots is suppressed; here only in normal mode or manual burst.
// [RULE_12] Overridden active bit delayed one flip-flop before decision.
// [RULE_13] Ready maintenance command 1-7, A, B selects test mode.
// [RULE_14] Under-test forces test mode; run commands C-F keep normal.
// [RULE_15] Decision delayed one clock, output as test and gate signals.
// [RULE_16] Gate loads main instruction register at execution period start.
// [RULE_17] Command runs in test processor slot or first free slot.
// [RULE_18] Fifteen command codes plus a no-op.
// [RULE_19] Controller starts and ends in state zero, waits for command.
// [RULE_20] Zero command is no-op; test slot with no-op stays idle.
// [RULE_21] Display and operand source flops pick switch or bus data.
// [RULE_22] Command D clears eight completion flags; each set on finish.
// [RULE_23] First-stage code from mask, selector at slot zero, else table.
// [RULE_24] Semi-auto or manual with commands 0-7 substitutes field code.
`timescale 1ns/1ps
module mss_sched
   import mss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`MSS_NUM_VP-1:0] instr_done,
   input wire logic [31:0] maint_data_bus,
   output logic [`MSS_VP_W-1:0] next_proc_code,
   output logic [`MSS_VP_W-1:0] cur_proc_code,
   output logic [`MSS_VP_W-1:0] maint_reg_proc,
   output logic test_mode,
   output logic normal_exec_indicator,
   output logic [31:0] operand_bus,
   output logic maint_idle
);

   ////////////////////////////////////////////////////////////////////
   // Decoding helpers
   // Inclusive range test on command codes, shared by several decodes
   function automatic logic cmd_in(input logic [`MSS_CMD_W-1:0] c,
                                   input logic [`MSS_CMD_W-1:0] lo,
                                   input logic [`MSS_CMD_W-1:0] hi);
      cmd_in = (c >= lo) && (c <= hi);
   endfunction : cmd_in

   ////////////////////////////////////////////////////////////////////
   // State
   // Console-side registers load over the register bus; the slot
   // counter, code pipeline and decision flops run on every clock.
   // Nothing here has a clock enable, so pipeline timing is fixed.
   logic [11:0] ctrl_r, ctrl_nxt;
   logic [17:0] cmd_r, cmd_nxt;
   logic [`MSS_NUM_VP-1:0] ovr_r, ovr_nxt;
   logic [31:0] swreg_r, swreg_nxt;
   logic [31:0] disp_r, disp_nxt;
   logic [`MSS_VP_W-1:0] tab_vp_r [`MSS_TS_DEPTH];
   logic [`MSS_TS_DEPTH-1:0] tab_act_r, tab_act_nxt;
   logic [`MSS_TS_W-1:0] ts_r, ts_nxt;
   logic [`MSS_VP_W-1:0] regvp_r, regvp_nxt;
   logic [`MSS_VP_W-1:0] pipe_r [`MSS_VP_DLY];
   logic [`MSS_VP_W-1:0] prev_vp_r, prev_vp_nxt;
   logic prev_act_r, prev_act_nxt;
   logic act_j_r, act_j_nxt;
   logic tm_r, tm_nxt;
   logic [`MSS_NUM_VP-1:0] done_r, done_nxt;
   mss_state_t st_r, st_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [`MSS_VP_W-1:0] cur_r;

   ////////////////////////////////////////////////////////////////////
   // Decodes
   // Mode code 3 is neither normal nor manual, so it acts like the
   // semi-automatic mode; software should not write it.
   // Apart from the bus strobes, the decodes below are pure functions of the registered state.
   mss_mode_t mode;
   logic manual, normal, ppbst, ts_zero, wr, rd, rd_ok;
   logic [`MSS_CMD_W-1:0] code;
   logic burst_cmd, illegal, cmd_ok;
   logic [`MSS_VP_W-1:0] first_vp, sel_vp, vp_j;
   logic act_tr, act_ovr, adj, vjeqvr, next_proc_under_test, maint_cmd_ready, maint_run_active;
   logic [`MSS_NUM_VP-1:0] ut_mask;

   // Mode, command and bus strobes
   // Burst codes outside manual are dropped here, so they never reach
   // the controller and cannot hold it in the run state.
   always_comb begin
      mode = mss_mode_t'(ctrl_r[`MSS_CTL_MODE]);
      manual = (mode == MSS_MODE_MANUAL);
      normal = (mode == MSS_MODE_NORMAL);
      ppbst = ctrl_r[`MSS_CTL_PPBST];
      ts_zero = (ts_r == `MSS_TS_ZERO);
      code = cmd_r[`MSS_CMD_CODE];
      burst_cmd = (code == `MSS_CMD_E) || (code == `MSS_CMD_F);
      illegal = burst_cmd && !manual; // RULE_10
      cmd_ok = (code != `MSS_CMD_NOP) && !illegal; // RULE_18
      wr = psel && penable && pwrite;
      rd = psel && !penable && !pwrite;
   end

   // First-stage code for three clocks ahead
   // The register-field substitution follows, so outside normal mode a command
   // 0-7 that names a processor reaches it even when the table would pick another.
   // Only the substituted code enters the pipeline.
   always_comb begin
      if (manual && !ppbst)
         first_vp = ctrl_r[`MSS_CTL_MASK]; // RULE_23
      else if (normal && ts_zero)
         first_vp = ctrl_r[`MSS_CTL_SEL]; // RULE_23
      else
         first_vp = tab_vp_r[ts_r]; // RULE_23
      if (!normal && cmd_in(code, `MSS_CMD_NOP, `MSS_CMD_7))
         sel_vp = cmd_r[`MSS_CMD_REGVP]; // RULE_24
      else
         sel_vp = first_vp; // RULE_02
   end

   // Active bit with overrides
   // Overrides look at the first-stage code, before substitution, so
   // a processor can lose its slot even while a command names it.
   // Back-to-back suppression uses the pre-override active bit of the last slot.
   always_comb begin
      vp_j = pipe_r[0];
      if ((manual && !ppbst) || (normal && ts_zero))
         act_tr = 1'b1; // RULE_05
      else
         act_tr = tab_act_r[ts_r]; // RULE_06
      act_ovr = act_tr;
      if (ovr_r[first_vp] &&
          (first_vp != ctrl_r[`MSS_CTL_SEL] || ctrl_r[`MSS_CTL_PERMIT]))
         act_ovr = 1'b0; // RULE_07 RULE_08
      if (burst_cmd && manual && ts_r[`MSS_TS_QUARTER_LSB] != 2'h0)
         act_ovr = 1'b0; // RULE_09
      adj = prev_act_r && (prev_vp_r == first_vp);
      if ((normal || (manual && ppbst)) && adj && act_tr)
         act_ovr = 1'b0; // RULE_11
   end

   // Test/normal decision terms
   // A run or burst command keeps normal mode so that the processors
   // it releases really execute; a free slot outside normal mode goes
   // to the maintenance side, where a no-op leaves it idle.
   always_comb begin
      vjeqvr = (vp_j == regvp_r);
      ut_mask = cmd_r[`MSS_CMD_UT];
      next_proc_under_test = ut_mask[vp_j] && cmd_in(code, `MSS_CMD_1, `MSS_CMD_B)
              && cmd_ok; // RULE_14
      maint_cmd_ready = cmd_ok && (st_r == MSS_ST_RUN) &&
              (cmd_in(code, `MSS_CMD_1, `MSS_CMD_7) ||
               code == `MSS_CMD_A || code == `MSS_CMD_B) &&
              (!normal || vjeqvr || !act_j_r); // RULE_13 RULE_17
      maint_run_active = cmd_ok && cmd_in(code, `MSS_CMD_C, `MSS_CMD_F); // RULE_14
      // Test mode when command ready or tested; run keeps normal
      tm_nxt = ((maint_cmd_ready || next_proc_under_test) && !maint_run_active) ||
               (!act_j_r && !maint_run_active && !normal); // RULE_13 RULE_14
   end

   ////////////////////////////////////////////////////////////////////
   // Controller and flags
   // The controller leaves ready only for a legal command and returns
   // only once the code is zeroed, so a stale code cannot start a
   // second run.
   always_comb begin
      st_nxt = st_r;
      done_nxt = done_r;
      unique case (st_r)
         MSS_ST_READY: if (cmd_ok) st_nxt = MSS_ST_RUN; // RULE_19
         MSS_ST_RUN: if (tm_r || maint_run_active) st_nxt = MSS_ST_DONE; // RULE_19
         MSS_ST_DONE: if (code == `MSS_CMD_NOP) st_nxt = MSS_ST_READY;
      endcase
      done_nxt = done_r | instr_done; // RULE_22
      if (code == `MSS_CMD_D && st_r == MSS_ST_READY)
         done_nxt = '0; // RULE_22
   end

   ////////////////////////////////////////////////////////////////////
   // Register writes and table
   // A bus write in the done state wins over the hardware clear for that
   // clock only; the code is zeroed on the next, so software must wait for ready.
   // The display register loads only in a granted test slot.
   always_comb begin
      ctrl_nxt = ctrl_r;
      cmd_nxt = cmd_r;
      ovr_nxt = ovr_r;
      swreg_nxt = swreg_r;
      tab_act_nxt = tab_act_r;
      disp_nxt = disp_r;
      if (wr) begin
         unique case (paddr[`MSS_A_ADDR_W-1:0])
            `MSS_A_CTRL: ctrl_nxt = pwdata[11:0];
            `MSS_A_CMD: cmd_nxt = pwdata[17:0];
            `MSS_A_OVR: ovr_nxt = pwdata[`MSS_NUM_VP-1:0];
            `MSS_A_SWREG: swreg_nxt = pwdata;
            `MSS_A_TSTAB:
               tab_act_nxt[pwdata[`MSS_TSW_IDX]] = pwdata[`MSS_TSW_ACT];
            default: ;
         endcase
      end
      if (st_r == MSS_ST_DONE && !wr)
         cmd_nxt[`MSS_CMD_CODE] = `MSS_CMD_NOP; // RULE_19
      if (st_r == MSS_ST_RUN && tm_r)
         disp_nxt = cmd_r[`MSS_CMD_DSRC] ? swreg_r
                                         : maint_data_bus; // RULE_21
      ts_nxt = ts_r + 4'h1;
      regvp_nxt = cmd_r[`MSS_CMD_REGVP]; // RULE_01
      prev_vp_nxt = first_vp;
      prev_act_nxt = act_tr;
      act_j_nxt = act_ovr; // RULE_12
   end

   // APB read mux
   // Read data is captured in the setup cycle and then held, so the
   // access phase never waits; unmapped offsets read as zero.
   // The error flag covers every offset outside the map.
   always_comb begin
      rd_ok = 1'b1;
      prdata_nxt = prdata_r;
      if (rd) begin
         unique case (paddr[`MSS_A_ADDR_W-1:0])
            `MSS_A_CTRL: prdata_nxt = {20'h0, ctrl_r};
            `MSS_A_CMD: prdata_nxt = {14'h0, cmd_r};
            `MSS_A_OVR: prdata_nxt = {24'h0, ovr_r};
            `MSS_A_STAT: prdata_nxt = {16'h0, done_r, 2'h0, st_r,
                                       ts_r};
            `MSS_A_SWREG: prdata_nxt = swreg_r;
            `MSS_A_DISP: prdata_nxt = disp_r;
            `MSS_A_MDB: prdata_nxt = maint_data_bus;
            default: prdata_nxt = 32'h0;
         endcase
      end
      unique case (paddr[`MSS_A_ADDR_W-1:0])
         `MSS_A_CTRL, `MSS_A_CMD, `MSS_A_OVR, `MSS_A_TSTAB, `MSS_A_STAT,
         `MSS_A_SWREG, `MSS_A_DISP, `MSS_A_MDB: rd_ok = 1'b1;
         default: rd_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Registers
   // Reset parks the scheduler in normal mode with an empty table, so
   // only the console selector's processor runs, in slot zero.
   // The controller starts in its ready state with a no-op loaded.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 12'h000;
         cmd_r <= 18'h00000;
         ovr_r <= 8'h00;
         swreg_r <= 32'h00000000;
         disp_r <= 32'h00000000;
         tab_act_r <= 16'h0000;
         ts_r <= 4'h0;
         regvp_r <= 3'h0;
         prev_vp_r <= 3'h0;
         prev_act_r <= 1'b0;
         act_j_r <= 1'b0;
         tm_r <= 1'b0;
         done_r <= 8'h00;
         st_r <= MSS_ST_READY;
         prdata_r <= 32'h00000000;
         cur_r <= 3'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cmd_r <= cmd_nxt;
         ovr_r <= ovr_nxt;
         swreg_r <= swreg_nxt;
         disp_r <= disp_nxt;
         tab_act_r <= tab_act_nxt;
         ts_r <= ts_nxt;
         regvp_r <= regvp_nxt; // RULE_01
         prev_vp_r <= prev_vp_nxt;
         prev_act_r <= prev_act_nxt;
         act_j_r <= act_j_nxt; // RULE_12
         tm_r <= tm_nxt; // RULE_15
         done_r <= done_nxt;
         st_r <= st_nxt;
         prdata_r <= prdata_nxt;
         cur_r <= pipe_r[`MSS_VP_DLY-1];
      end
   end

   // Three-stage processor code pipeline
   // Stage zero holds the code two clocks ahead, the last stage the
   // next code; the under-test compare taps stage zero.
   // Current code is one more flop behind the last stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `MSS_VP_DLY; i++)
            pipe_r[i] <= 3'h0;
      end else begin
         pipe_r[0] <= sel_vp; // RULE_03
         for (int i = 1; i < `MSS_VP_DLY; i++)
            pipe_r[i] <= pipe_r[i-1]; // RULE_03
      end
   end

   // Slot table processor codes
   // One entry is rewritten per bus write; the active bit of the same
   // entry changes in the register write logic on that edge.
   // The table is only written, never read back over the bus.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `MSS_TS_DEPTH; i++)
            tab_vp_r[i] <= 3'h0;
      end else if (wr && paddr[`MSS_A_ADDR_W-1:0] == `MSS_A_TSTAB) begin
         tab_vp_r[pwdata[`MSS_TSW_IDX]] <= pwdata[`MSS_TSW_VP];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   // All outputs but the bus handshake, the gate, the operand mux and the idle
   // flag come straight from flops, so the processor sees clean levels.
   // The gate is the inverse of the test indicator by construction.
   always_comb begin
      prdata = prdata_r;
      pready = 1'b1;
      pslverr = psel && penable && !rd_ok;
      next_proc_code = pipe_r[`MSS_VP_DLY-1]; // RULE_04
      cur_proc_code = cur_r; // RULE_04
      maint_reg_proc = regvp_r; // RULE_01
      test_mode = tm_r; // RULE_15
      normal_exec_indicator = !tm_r; // RULE_15 RULE_16
      operand_bus = cmd_r[`MSS_CMD_OSRC] ? swreg_r : disp_r; // RULE_21
      maint_idle = tm_r && (code == `MSS_CMD_NOP); // RULE_20
   end

endmodule : mss_sched

// ### verif/mss_sched_props.sv
// Purpose: Port checker for the slot scheduler.
// Assumes: Sees only top module ports.
// Notes: Bound into every scheduler instance.
`timescale 1ns/1ps
`include "mss_consts.svh"
module mss_sched_props
   import mss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [`MSS_VP_W-1:0] next_proc_code,
   input wire logic [`MSS_VP_W-1:0] cur_proc_code,
   input wire logic [`MSS_VP_W-1:0] maint_reg_proc,
   input wire logic test_mode,
   input wire logic normal_exec_indicator,
   input wire logic maint_idle
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_cmd;
   logic bad_a;
   // Command write strobe, unmapped address
   assign wr_cmd = psel && penable && pwrite && paddr == {20'h0, `MSS_A_CMD};
   assign bad_a = !(paddr[`MSS_A_ADDR_W-1:0] inside {`MSS_A_CTRL,
      `MSS_A_CMD, `MSS_A_OVR, `MSS_A_TSTAB, `MSS_A_STAT, `MSS_A_SWREG,
      `MSS_A_DISP, `MSS_A_MDB});
   ////////////////////////////////////////////////////////////////////////
   property p_gate; normal_exec_indicator == !test_mode; endproperty
   a_gate: assert property (p_gate) else $error("gate not inverse");
   property p_pipe; 1'b1 |=> cur_proc_code == $past(next_proc_code); endproperty
   a_pipe: assert property (p_pipe) else $error("code stage lost");
   property p_regvp;
      wr_cmd |=> ##1 maint_reg_proc == $past(pwdata[`MSS_CMD_REGVP], 2);
   endproperty
   a_regvp: assert property (p_regvp) else $error("field code delay");
   property p_idle; maint_idle |-> test_mode; endproperty
   a_idle: assert property (p_idle) else $error("idle outside test");
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_map; psel && penable |-> pslverr == bad_a; endproperty
   a_map: assert property (p_map) else $error("error response wrong");
   property p_rdz; psel && !penable && !pwrite && bad_a |=> prdata == 0;
   endproperty
   a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
   property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule : mss_sched_props
bind mss_sched mss_sched_props u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .next_proc_code,
   .cur_proc_code, .maint_reg_proc, .test_mode, .normal_exec_indicator,
   .maint_idle);

// ### verif/mss_proc_model.sv
// Purpose: Processor side model for the slot scheduler.
// Assumes: Bench asks for finish pulses.
// Notes: Data bus changes every cycle.
`timescale 1ns/1ps
`include "mss_consts.svh"
module mss_proc_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fire,
   input wire logic [`MSS_NUM_VP-1:0] bits,
   output logic [`MSS_NUM_VP-1:0] instr_done,
   output logic [31:0] maint_data_bus
);
   // One-cycle finish pulses, never-still data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_done <= '0;
         maint_data_bus <= 32'h0;
      end else begin
         instr_done <= fire ? bits : '0;
         maint_data_bus <= {maint_data_bus[30:0], ~maint_data_bus[31]};
      end
   end
endmodule : mss_proc_model

// ### verif/testbench.sv
// Purpose: Self-checking bench for the slot scheduler.
// Assumes: Zero-wait APB slave.
// Notes: Fixed seed, random codes and data.
`timescale 1ns/1ps
`include "mss_consts.svh"
module testbench;
   import mss_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, fire, er, hit;
   logic pready, pslverr, test_mode, normal_exec_indicator, maint_idle;
   logic [31:0] paddr, pwdata, prdata, maint_data_bus, operand_bus, rd, x;
   logic [7:0] bits, instr_done;
   logic [2:0] next_proc_code, cur_proc_code, maint_reg_proc, r, m;
   int error_cnt, cmp_count;
   mss_sched DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .instr_done, .maint_data_bus,
      .next_proc_code, .cur_proc_code, .maint_reg_proc, .test_mode,
      .normal_exec_indicator, .operand_bus, .maint_idle);
   mss_proc_model PM (.pclk, .presetn, .fire, .bits, .instr_done,
      .maint_data_bus);
   ////////////////////////////////////////////////////////////////////////
   // Bench clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Let n edges pass, then sample mid-cycle where outputs have settled
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : settle
   // One transfer, answer taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {20'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1)
         error_cnt++; // Timeout counts as a mismatch
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Manual mode control and command words
   function automatic logic [31:0] ctl(logic p, logic [2:0] s, k);
      return {21'h0, k, 1'b0, s, p, 3'h2};
   endfunction : ctl
   function automatic logic [31:0] cmdw(logic [3:0] c, logic [7:0] u,
      logic o);
      return {14'h0, o, 1'b0, u, 1'b0, r, c};
   endfunction : cmdw
   function automatic logic ovr_hit(logic is_sel, logic p);
      return !is_sel || p;
   endfunction : ovr_hit
   ////////////////////////////////////////////////////////////////////////
   initial begin
      x = $urandom(32'h0FF21E61);
      {presetn, psel, penable, pwrite, fire, bits, r} = '0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `MSS_A_CTRL, 32'h0);
      chk("ctrl", rd, 32'h0);
      chk("gate", {31'h0, normal_exec_indicator}, 32'h1);
      $display("reset test done");
      for (int i = 0; i < 3; i++) begin
         r = 3'($urandom);
         m = r + 3'($urandom_range(6, 1));
         apb(1'b1, `MSS_A_CTRL, ctl(1'b0, m, m));
         apb(1'b1, `MSS_A_CMD, cmdw(4'h0, 8'h00, 1'b0));
         settle(8);
         chk("cur", {29'h0, cur_proc_code}, {29'h0, r});
         chk("next", {29'h0, next_proc_code}, {29'h0, r});
         chk("regvp", {29'h0, maint_reg_proc}, {29'h0, r});
         chk("test", {31'h0, test_mode}, 32'h0);
         // Override bit on the mask processor, selector on or off it
         for (int k = 0; k < 3; k++) begin
            apb(1'b1, `MSS_A_CTRL, ctl(k == 2, (k != 0) ? m : r, m));
            apb(1'b1, `MSS_A_OVR, 32'h1 << m);
            settle(8);
            hit = ovr_hit(k != 0, k == 2);
            chk("ovr", {31'h0, test_mode}, {31'h0, hit});
            chk("idle", {31'h0, maint_idle}, {31'h0, hit});
         end
         apb(1'b1, `MSS_A_OVR, 32'h0);
         // Code 8 does no work of its own, only the under-test term
         apb(1'b1, `MSS_A_CMD, cmdw(4'h8, 8'h01 << m, 1'b0));
         settle(2);
         chk("ut", {31'h0, test_mode}, 32'h1);
         // Continuous command stands three clocks before its clear
         apb(1'b1, `MSS_A_CMD, cmdw(4'hF, 8'h00, 1'b0));
         settle(4);
         chk("mask", {29'h0, cur_proc_code}, {29'h0, m});
         apb(1'b1, `MSS_A_CMD, 32'h0);
      end
      $display("slot test done");
      x = $urandom;
      apb(1'b1, `MSS_A_SWREG, x);
      apb(1'b1, `MSS_A_CMD, cmdw(4'h0, 8'h00, 1'b1));
      apb(1'b0, `MSS_A_SWREG, 32'h0);
      chk("swreg", rd, x);
      chk("opbus", operand_bus, x);
      $display("operand test done");
      x = 32'($urandom_range(255, 1));
      bits <= x[7:0];
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, `MSS_A_STAT, 32'h0);
      chk("flags", {24'h0, rd[15:8]}, {24'h0, x[7:0]});
      apb(1'b1, `MSS_A_CMD, cmdw(4'hD, 8'h00, 1'b0));
      apb(1'b0, `MSS_A_STAT, 32'h0);
      chk("clear", {24'h0, rd[15:8]}, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", {31'h0, er}, 32'h1);
      chk("unmapped", rd, 32'h0);
      $display("flag test done");
      give_verdict();
   end
endmodule : testbench
